// ---- logic/ebs_defines.vh ----
// constants for the encoder battery supervisor
`ifndef EBS_DEFINES_VH
`define EBS_DEFINES_VH
// register byte addresses
`define EBS_ADDR_CFG 12'h000
`define EBS_ADDR_STAT 12'h004
`define EBS_ADDR_IRQ_STAT 12'h008
`define EBS_ADDR_IRQ_MASK 12'h00c
`define EBS_ADDR_CTRL 12'h010
// field positions
`define EBS_CFG_SEL_BIT 0
`define EBS_STAT_ALARM_BIT 0
`define EBS_STAT_WARN_BIT 1
`define EBS_STAT_SERVO_BIT 2
`define EBS_STAT_MON_BIT 3
`define EBS_STAT_MODE_BIT 4
`define EBS_STAT_LOW_BIT 5
`define EBS_EV_ALARM_BIT 0
`define EBS_EV_WARN_BIT 1
`define EBS_EV_DONE_BIT 2
// reset values
`define EBS_CFG_RESET 1'b0
`define EBS_MASK_RESET 3'h0
// timing, seconds and clock rate
`define EBS_CLK_HZ 200000000
`define EBS_ALARM_OUT_S 5
`define EBS_MONITOR_S 4
`define EBS_ALARM_OUT_CYC (`EBS_ALARM_OUT_S * `EBS_CLK_HZ)
`define EBS_MONITOR_CYC (`EBS_MONITOR_S * `EBS_CLK_HZ)
`endif

// ---- logic/ebs_window_timer.v ----
// down counter timing the power-on windows
`timescale 1ns/1ps
module ebs_window_timer (
  input wire pclk,
  input wire presetn,
  input wire load,
  input wire [31:0] load_val,
  output wire expired
);
  reg [31:0] cnt_q;
  assign expired = (cnt_q == 32'h0000_0000);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 32'h0000_0000;
    end else if (load) begin
      cnt_q <= load_val;
    end else if (cnt_q != 32'h0000_0000) begin
      cnt_q <= cnt_q - 32'h0000_0001;
    end
  end
endmodule // ebs_window_timer

// ---- logic/ebs_apb_slave.v ----
// apb register slave for the battery supervisor
`timescale 1ns/1ps
`include "ebs_defines.vh"
module ebs_apb_slave (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [5:0] status,
  input wire [2:0] events,
  output wire report_sel,
  output wire power_on_pulse,
  output wire irq
);
  reg [31:0] prdata_q;
  reg sel_q;
  reg [2:0] irq_stat_q;
  reg [2:0] irq_mask_q;
  reg pon_q;
  wire acc;
  wire wr;
  wire rd;
  wire mapped;
  wire rd_stat;
  assign acc = psel & penable;
  assign wr = acc & pwrite;
  assign rd = acc & ~pwrite;
  assign rd_stat = rd & (paddr == `EBS_ADDR_IRQ_STAT);
  assign mapped = (paddr == `EBS_ADDR_CFG) | (paddr == `EBS_ADDR_STAT) |
    (paddr == `EBS_ADDR_IRQ_STAT) | (paddr == `EBS_ADDR_IRQ_MASK) | (paddr == `EBS_ADDR_CTRL);
  assign pready = 1'b1;
  assign pslverr = acc & ~mapped;
  assign prdata = prdata_q;
  assign report_sel = sel_q;
  assign power_on_pulse = pon_q;
  assign irq = |(irq_stat_q & irq_mask_q);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_q <= `EBS_CFG_RESET;
      irq_mask_q <= `EBS_MASK_RESET;
      irq_stat_q <= 3'h0;
      pon_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pon_q <= wr & (paddr == `EBS_ADDR_CTRL) & pwdata[0];
      if (wr && paddr == `EBS_ADDR_CFG)
        sel_q <= pwdata[`EBS_CFG_SEL_BIT];
      if (wr && paddr == `EBS_ADDR_IRQ_MASK)
        irq_mask_q <= pwdata[2:0];
      // only bits already reported are cleared, so an event landing between
      // setup and access survives; a new event also wins over the clear
      irq_stat_q <= (irq_stat_q & ~(rd_stat ? prdata_q[2:0] : 3'h0)) | events;
      // read data is captured in setup so it stands through the access edge
      if (psel && !penable && !pwrite) begin
        case (paddr)
          `EBS_ADDR_CFG: prdata_q <= {31'h0, sel_q};
          `EBS_ADDR_STAT: prdata_q <= {26'h0, status};
          `EBS_ADDR_IRQ_STAT: prdata_q <= {29'h0, irq_stat_q};
          `EBS_ADDR_IRQ_MASK: prdata_q <= {29'h0, irq_mask_q};
          default: prdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule // ebs_apb_slave

// ---- logic/ebs_battery_supervisor.v ----
// encoder backup battery supervisor top
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "ebs_defines.vh"
// Operation
// - low comparator means battery at or below threshold
// - select 0 gives alarm, latched at restart
// - select 1 gives warning instead
// - alarm output window, then four second sampling in alarm mode
// - alarm mode ignores lows after window
// - warning mode monitors continuously after window
// - alarm latched until next power cycle
module ebs_battery_supervisor #(
  parameter [31:0] ALARM_OUT_CYC = `EBS_ALARM_OUT_CYC,
  parameter [31:0] MONITOR_CYC = `EBS_MONITOR_CYC
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire battery_low,
  input wire control_power_on,
  output wire servo_alarm_output,
  output wire battery_alarm,
  output wire battery_warning,
  output wire irq
);
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_ALMOUT = 4'b0010;
  localparam [3:0] ST_MON = 4'b0100;
  localparam [3:0] ST_RUN = 4'b1000;

  // every flop has its own next-value net
  reg [3:0] state_q;
  reg [3:0] state_d;
  reg mode_q;
  reg mode_d;
  reg alarm_q;
  reg alarm_d;
  reg warn_q;
  reg warn_d;
  reg servo_q;
  reg servo_d;
  reg [2:0] events_q;
  reg [2:0] events_d;

  // timer reload request
  reg load;
  reg [31:0] load_val;
  reg [5:0] status;

  // decoded state and strobes
  wire report_sel;
  wire sw_power_on;
  wire power_on;
  wire expired;
  wire in_almout;
  wire in_mon;
  wire in_run;
  wire startup_done;
  wire alarm_hit;
  wire warn_track;

  // one-hot membership test
  function in_state;
    input [3:0] cur;
    input [3:0] st;
    begin
      in_state = |(cur & st);
    end
  endfunction

  // state entered when the servo alarm output window ends
  function [3:0] after_startup;
    input mode;
    begin
      case (mode)
        1'b1: begin
          after_startup = ST_RUN;
        end
        default: begin
          after_startup = ST_MON;
        end
      endcase
    end
  endfunction

  // rising edge of a level against its registered copy
  function rising;
    input now;
    input was;
    begin
      rising = now & ~was;
    end
  endfunction

  assign power_on = control_power_on | sw_power_on;
  assign in_almout = in_state(state_q, ST_ALMOUT);
  assign in_mon = in_state(state_q, ST_MON);
  assign in_run = in_state(state_q, ST_RUN);
  assign startup_done = in_almout & expired;
  // alarm mode samples only inside the window
  assign alarm_hit = ~mode_q & in_mon & battery_low & ~alarm_q;
  // warning follows the comparator once running
  assign warn_track = mode_q & in_run;

  // outputs
  assign servo_alarm_output = servo_q;
  assign battery_alarm = alarm_q;
  assign battery_warning = warn_q;

  // status fields are placed by the shared bit positions
  always @* begin
    status = 6'h00;
    // the live comparator level is shown so software can watch a swap
    status[`EBS_STAT_ALARM_BIT] = alarm_q;
    status[`EBS_STAT_WARN_BIT] = warn_q;
    status[`EBS_STAT_SERVO_BIT] = servo_q;
    status[`EBS_STAT_MON_BIT] = in_mon;
    status[`EBS_STAT_MODE_BIT] = mode_q;
    status[`EBS_STAT_LOW_BIT] = battery_low;
  end

  ebs_window_timer u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .load(load),
    .load_val(load_val),
    .expired(expired)
  );

  ebs_apb_slave u_regs (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .status(status),
    .events(events_q),
    .report_sel(report_sel),
    .power_on_pulse(sw_power_on),
    .irq(irq)
  );

  // windows come from one cycle counter
  always @* begin
    state_d = state_q;
    // a restart always wins over the sequencer
    if (power_on) begin
      state_d = ST_ALMOUT;
    end else begin
      case (state_q)
        ST_IDLE: begin
          state_d = ST_IDLE;
        end
        ST_ALMOUT: begin
          // warning mode skips the sampling window
          if (expired) begin
            state_d = after_startup(mode_q);
          end
        end
        ST_MON: begin
          if (expired) begin
            state_d = ST_RUN;
          end
        end
        ST_RUN: begin
          state_d = ST_RUN;
        end
        default: begin
          state_d = ST_IDLE;
        end
      endcase
    end
  end

  // the timer is reloaded at power on and again for the monitoring window
  always @* begin
    load = 1'b0;
    load_val = ALARM_OUT_CYC;
    if (power_on) begin
      load = 1'b1;
    end else if (startup_done) begin
      load = 1'b1;
      load_val = MONITOR_CYC;
    end
  end

  // selection only takes effect at a restart
  always @* begin
    mode_d = mode_q;
    if (power_on) begin
      mode_d = report_sel;
    end
  end

  // latched until the next power cycle
  always @* begin
    alarm_d = alarm_q;
    if (power_on) begin
      alarm_d = 1'b0;
    end else if (alarm_hit) begin
      alarm_d = 1'b1;
    end
  end

  // warning flag tracks the comparator level
  always @* begin
    warn_d = warn_q;
    if (power_on) begin
      warn_d = 1'b0;
    end else if (warn_track) begin
      warn_d = battery_low;
    end
  end

  // an alarm keeps the servo alarm output up after the start window
  always @* begin
    servo_d = servo_q;
    if (power_on) begin
      servo_d = 1'b1;
    end else if (alarm_hit) begin
      servo_d = 1'b1;
    end else if (startup_done) begin
      servo_d = alarm_q;
    end
  end

  // one-cycle event pulses for the sticky status bits
  always @* begin
    events_d = 3'h0;
    if (!power_on) begin
      events_d[`EBS_EV_DONE_BIT] = startup_done;
      events_d[`EBS_EV_ALARM_BIT] = alarm_hit;
      events_d[`EBS_EV_WARN_BIT] = warn_track & rising(battery_low, warn_q);
    end
  end

  // power-on reset leaves everything idle until the first restart
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // mode is held between restarts
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= `EBS_CFG_RESET;
    end else begin
      mode_q <= mode_d;
    end
  end

  // alarm flag
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_q <= 1'b0;
    end else begin
      alarm_q <= alarm_d;
    end
  end

  // warning flag
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      warn_q <= 1'b0;
    end else begin
      warn_q <= warn_d;
    end
  end

  // servo alarm output
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      servo_q <= 1'b0;
    end else begin
      servo_q <= servo_d;
    end
  end

  // event pulses last one cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      events_q <= 3'h0;
    end else begin
      events_q <= events_d;
    end
  end
endmodule // ebs_battery_supervisor

// ---- testbench/ebs_checker.sv ----
// assertion checker for the battery supervisor outputs
`timescale 1ns/1ps
module ebs_checker #(
  parameter [31:0] ALARM_OUT_CYC = 20,
  parameter [31:0] MONITOR_CYC = 16
) (
  input wire pclk,
  input wire presetn,
  input wire battery_low,
  input wire control_power_on,
  input wire servo_alarm_output,
  input wire battery_alarm,
  input wire battery_warning
);
  // cycles since the last power-on pulse, counting from reset until the first one
  reg [31:0] cnt_q;
  always @(posedge pclk or negedge presetn)
    if (!presetn)
      cnt_q <= 32'h0;
    else if (control_power_on)
      cnt_q <= 32'h1;
    else if (cnt_q != 32'hffffffff)
      cnt_q <= cnt_q + 32'h1;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence pon_s;
    control_power_on;
  endsequence
  sequence hold_s;
    battery_alarm && !control_power_on;
  endsequence
  a_start_servo: assert property (pon_s |=> servo_alarm_output)
    else $error("servo output not raised at power on");
  a_pon_clear: assert property (pon_s |=> !battery_alarm && !battery_warning)
    else $error("flags not cleared at power on");
  a_alarm_latch: assert property (hold_s |=> battery_alarm)
    else $error("alarm dropped without power cycle");
  a_alarm_servo: assert property (battery_alarm |-> servo_alarm_output)
    else $error("alarm without servo output");
  a_late_ignored: assert property ($rose(battery_alarm) |-> cnt_q != 32'h0 &&
    cnt_q <= ALARM_OUT_CYC + MONITOR_CYC + 32'h3) else $error("alarm after window");
  a_low_cause: assert property ($rose(battery_alarm) |-> $past(battery_low))
    else $error("alarm without low battery");
  a_one_kind: assert property (!(battery_alarm && battery_warning))
    else $error("alarm and warning together");
  a_warn_follow: assert property ($rose(battery_warning) |-> $past(battery_low))
    else $error("warning without low battery");
endmodule // ebs_checker
bind ebs_battery_supervisor ebs_checker #(
  .ALARM_OUT_CYC(ALARM_OUT_CYC),
  .MONITOR_CYC(MONITOR_CYC)
) chk_u (
  .pclk(pclk),
  .presetn(presetn),
  .battery_low(battery_low),
  .control_power_on(control_power_on),
  .servo_alarm_output(servo_alarm_output),
  .battery_alarm(battery_alarm),
  .battery_warning(battery_warning)
);

// ---- testbench/ebs_battery_model.sv ----
// comparator model of the backup battery voltage
`timescale 1ns/1ps
module ebs_battery_model (
  input wire pclk,
  input wire drained,
  output reg battery_low
);
  initial battery_low = 1'b0;
  // low means at or below threshold, synchronised to pclk
  always @(posedge pclk)
    battery_low <= drained;
endmodule // ebs_battery_model

// ---- testbench/ebs_battery_supervisor_bench.sv ----
// self-checking bench for the battery supervisor
`timescale 1ns/1ps
`include "ebs_defines.vh"
module ebs_battery_supervisor_bench;
  localparam W = 20;
  localparam M = 16;
  reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, drain = 0, pon = 0, err;
  reg [11:0] paddr = 12'h0;
  reg [31:0] pwdata = 32'h0, rd;
  wire [31:0] prdata;
  wire pready, pslverr, low, servo, alarm, warn, irq;
  integer fail_count = 0, n_tests = 0, cyc = 0, i;
  always #2.5 pclk = ~pclk;
  ebs_battery_model mdl_u (.pclk(pclk), .drained(drain), .battery_low(low));
  ebs_battery_supervisor #(.ALARM_OUT_CYC(W), .MONITOR_CYC(M)) dut_u (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .battery_low(low), .control_power_on(pon), .servo_alarm_output(servo),
    .battery_alarm(alarm), .battery_warning(warn), .irq(irq));
  task chk(input [31:0] seen, input [31:0] exp, input [8*12-1:0] what);
    n_tests = n_tests + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("MISMATCH %0s expected %h seen %h", what, exp, seen);
    end
  endtask
  // read data stands from setup, so it is taken at the access edge
  task apb(input w, input [11:0] a, input [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    err = pslverr;
    rd = prdata;
    psel <= 0;
    penable <= 0;
    @(negedge pclk);
  endtask
  task pwr;
    @(posedge pclk);
    pon <= 1;
    @(posedge pclk);
    pon <= 0;
  endtask
  task results;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      fail_count = fail_count + 1;
      results;
    end
  end
  initial begin
    void'($urandom(77654));
    repeat (16) @(posedge pclk);
    presetn <= 1;
    apb(0, `EBS_ADDR_CFG, 0);
    chk(rd, 32'h0, "cfg reset");
    apb(1, `EBS_ADDR_IRQ_MASK, 32'h7);
    drain <= 1;
    pwr;
    repeat (W + M + 4) @(posedge pclk);
    chk({servo, alarm, warn, irq}, 4'hd, "alarm outs");
    apb(0, `EBS_ADDR_STAT, 0);
    chk(rd, 32'h25, "status");
    // battery swapped with control power kept on
    drain <= 0;
    apb(0, `EBS_ADDR_IRQ_STAT, 0);
    chk({rd[0], alarm, irq}, 3'h6, "irq clear");
    pwr;
    repeat (W + M + 4 + $urandom % 8) @(posedge pclk);
    drain <= 1;
    repeat (8) @(posedge pclk);
    chk({servo, alarm}, 2'h0, "late low");
    apb(1, `EBS_ADDR_CFG, 1);
    chk(alarm, 0, "no alarm");
    // restart by software this time
    apb(1, `EBS_ADDR_CTRL, 1);
    repeat (W + 4) @(posedge pclk);
    for (i = 0; i < 8; i = i + 1) begin
      drain <= 1'($urandom);
      repeat (4) @(posedge pclk);
      chk({alarm, warn}, {1'b0, drain}, "warn track");
    end
    apb(0, 12'h014, 0);
    chk({31'h0, err}, 32'h1, "slverr");
    chk(rd, 32'h0, "bad rdata");
    results;
  end
endmodule // ebs_battery_supervisor_bench
